// ### lsm_uart.sv
// The implementer's own choice: the address-and-strobe port.
`default_nettype none
module lsm_uart
    import lsm_pkg::*;
(
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    // register port
    input wire lsm_bus_req_t i_req,
    output logic [7:0] o_rdata,
    // serial line and modem pins
    input wire logic i_rx,
    output logic o_tx,
    input wire lsm_modem_in_t i_modem_n,
    output logic o_rts_n,
    output logic o_dtr_n,
    // interrupt
    output logic o_irq
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] div_lo;
        logic [7:0] div_hi;
        logic [3:0] irq_en;
        logic fifo_en;
        logic [7:0] line_ctrl;
        logic [4:0] modem_ctrl;
        logic [7:0] scratch;
        logic [2:0] rx_sync;
        logic rx_line;
        logic [3:0] m_sync0;
        logic [3:0] m_sync1;
        logic [3:0] m_sync2;
        logic [3:0] m_pin;
        logic [3:0] m_stat;
        logic [3:0] m_delta;
        logic [15:0] baud_cnt;
        lsm_rx_st_t rx_st;
        logic [3:0] rx_cnt;
        logic [2:0] rx_bit;
        logic [7:0] rx_shift;
        logic rx_pe;
        logic rx_zero;
        lsm_tx_st_t tx_st;
        logic [4:0] tx_cnt;
        logic [2:0] tx_bit;
        logic [7:0] tx_shift;
        logic tx_par;
        logic tx_line;
        logic [FIFO_DEPTH-1:0][10:0] rx_mem;
        logic [3:0] rx_wp;
        logic [3:0] rx_rp;
        logic [4:0] rx_count;
        logic [4:0] rx_errs;
        logic [FIFO_DEPTH-1:0][7:0] tx_mem;
        logic [3:0] tx_wp;
        logic [3:0] tx_rp;
        logic [4:0] tx_count;
        logic overrun;
        logic [2:0] head_err;
        logic fifo_err;
        logic thre;
        logic temt;
        logic [7:0] rdata;
        logic tx_pin;
        logic irq;
        logic [1:0] mdm_out_n;
    } lsm_state_t;

    lsm_state_t q, d;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [2:0] last_bit(input logic [7:0] lc);
        return {1'b0, lc[1:0]} + 3'h4;
    endfunction : last_bit

    function automatic logic [7:0] len_mask(input logic [7:0] lc);
        return 8'hff >> (2'h3 - lc[1:0]);
    endfunction : len_mask

    function automatic logic par_bit(input logic [7:0] data, input logic [7:0] lc);
        logic ones;
        ones = ^(data & len_mask(lc));
        if (lc[LC_PAR_STICK]) begin
            return ~lc[LC_PAR_EVEN];
        end
        return lc[LC_PAR_EVEN] ? ones : ~ones;
    endfunction : par_bit

    function automatic logic [4:0] stop_last(input logic [7:0] lc);
        if (!lc[LC_STOP]) begin
            return STOP1_LAST;
        end
        return (lc[1:0] == 2'h0) ? STOP15_LAST : STOP2_LAST;
    endfunction : stop_last

    logic wr, rd, dlab, tick, rx_in, rx_done, tx_pop, tx_push, lsr_rd;
    logic rx_push, rx_pop, rx_rst, tx_rst, pending;
    logic [15:0] divisor;
    logic [4:0] cap;
    logic [3:0] m_now;
    logic [2:0] head_set, iid;
    logic [7:0] rx_data, lsr_val;
    lsm_rx_ent_t rx_ent, next_head;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        d = q;
        wr = i_req.wr;
        rd = i_req.rd;
        dlab = q.line_ctrl[LC_DLAB];
        rx_done = 1'b0;
        tx_pop = 1'b0;
        tx_push = 1'b0;
        rx_push = 1'b0;
        rx_rst = 1'b0;
        tx_rst = 1'b0;
        head_set = 3'h0;
        rx_data = 8'h00;
        rx_ent = '0;
        next_head = '0;
        cap = q.fifo_en ? CAP_FIFO : CAP_LEGACY;
        d.rdata = 8'h00;

        // pin synchronisers: a change counts once stages two and three agree
        d.rx_sync = {q.rx_sync[1:0], i_rx};
        if (q.rx_sync[1] == q.rx_sync[2]) begin
            d.rx_line = q.rx_sync[2];
        end
        d.m_sync0 = i_modem_n;
        d.m_sync1 = q.m_sync0;
        d.m_sync2 = q.m_sync1;
        for (int i = 0; i < 4; i++) begin
            if (q.m_sync1[i] == q.m_sync2[i]) begin
                d.m_pin[i] = q.m_sync2[i];
            end
        end
        m_now = q.modem_ctrl[MC_LOOP]
              ? {q.modem_ctrl[MC_IRQ_EN], q.modem_ctrl[MC_RI],
                 q.modem_ctrl[MC_DTR], q.modem_ctrl[MC_RTS]}
              : ~q.m_pin;
        d.m_stat = m_now;

        // 16x baud tick; a zero divisor behaves as one
        divisor = {q.div_hi, q.div_lo};
        tick = (q.baud_cnt == 16'h0000);
        if (tick) begin
            d.baud_cnt = (divisor == 16'h0000) ? 16'h0000 : 16'(divisor - 16'h0001);
        end else begin
            d.baud_cnt = 16'(q.baud_cnt - 16'h0001);
        end

        // ------------------------------------------------------------
        // receiver
        // ------------------------------------------------------------
        rx_in = q.modem_ctrl[MC_LOOP] ? q.tx_line : q.rx_line;
        if (tick) begin
            d.rx_cnt = 4'(q.rx_cnt + 4'h1);
            case (q.rx_st)
                RX_IDLE: begin
                    d.rx_cnt = 4'h0;
                    if (!rx_in) begin
                        d.rx_st = RX_START;
                    end
                end
                RX_START: begin
                    if (q.rx_cnt == OVS_MID) begin
                        d.rx_cnt = 4'h0;
                        d.rx_bit = 3'h0;
                        d.rx_zero = 1'b1;
                        d.rx_st = rx_in ? RX_IDLE : RX_DATA;
                    end
                end
                RX_DATA: begin
                    if (q.rx_cnt == OVS_LAST) begin
                        d.rx_shift = {rx_in, q.rx_shift[7:1]};
                        d.rx_zero = q.rx_zero & ~rx_in;
                        d.rx_bit = 3'(q.rx_bit + 3'h1);
                        if (q.rx_bit == last_bit(q.line_ctrl)) begin
                            d.rx_st = q.line_ctrl[LC_PAR_EN] ? RX_PARITY : RX_STOP;
                        end
                    end
                end
                RX_PARITY: begin
                    if (q.rx_cnt == OVS_LAST) begin
                        // rx_bit has already advanced past the last data bit here
                        rx_data = q.rx_shift >> (3'h7 - last_bit(q.line_ctrl));
                        d.rx_pe = (rx_in != par_bit(rx_data, q.line_ctrl));
                        d.rx_zero = q.rx_zero & ~rx_in;
                        d.rx_st = RX_STOP;
                    end
                end
                RX_STOP: begin
                    if (q.rx_cnt == OVS_LAST) begin
                        rx_done = 1'b1;
                        d.rx_st = rx_in ? RX_IDLE : RX_HOLD;
                    end
                end
                RX_HOLD: begin
                    // a held-low line must rise before another start is taken
                    d.rx_cnt = 4'h0;
                    if (rx_in) begin
                        d.rx_st = RX_IDLE;
                    end
                end
                default: d.rx_st = RX_IDLE;
            endcase
        end
        if (rx_done) begin
            rx_ent.data = (q.rx_shift >> (3'h7 - last_bit(q.line_ctrl)));
            rx_ent.pe = q.line_ctrl[LC_PAR_EN] & q.rx_pe;
            rx_ent.fe = ~rx_in;
            rx_ent.brk = q.rx_zero & ~rx_in;
        end
        if (!rx_done) begin
            d.rx_pe = q.rx_st == RX_IDLE ? 1'b0 : d.rx_pe;
        end

        // ------------------------------------------------------------
        // transmitter
        // ------------------------------------------------------------
        if (tick) begin
            d.tx_cnt = 5'(q.tx_cnt + 5'h01);
            case (q.tx_st)
                TX_IDLE: begin
                    d.tx_cnt = 5'h00;
                    if (q.tx_count != 5'h00) begin
                        tx_pop = 1'b1;
                        d.tx_shift = q.tx_mem[q.tx_rp];
                        d.tx_par = par_bit(q.tx_mem[q.tx_rp], q.line_ctrl);
                        d.tx_line = 1'b0;
                        d.tx_st = TX_START;
                    end
                end
                TX_START: begin
                    if (q.tx_cnt[3:0] == OVS_LAST) begin
                        d.tx_cnt = 5'h00;
                        d.tx_bit = 3'h0;
                        d.tx_line = q.tx_shift[0];
                        d.tx_st = TX_DATA;
                    end
                end
                TX_DATA: begin
                    if (q.tx_cnt[3:0] == OVS_LAST) begin
                        d.tx_cnt = 5'h00;
                        d.tx_shift = {1'b0, q.tx_shift[7:1]};
                        d.tx_bit = 3'(q.tx_bit + 3'h1);
                        d.tx_line = q.tx_shift[1];
                        if (q.tx_bit == last_bit(q.line_ctrl)) begin
                            d.tx_line = q.line_ctrl[LC_PAR_EN] ? q.tx_par : 1'b1;
                            d.tx_st = q.line_ctrl[LC_PAR_EN] ? TX_PARITY : TX_STOP;
                        end
                    end
                end
                TX_PARITY: begin
                    if (q.tx_cnt[3:0] == OVS_LAST) begin
                        d.tx_cnt = 5'h00;
                        d.tx_line = 1'b1;
                        d.tx_st = TX_STOP;
                    end
                end
                TX_STOP: begin
                    if (q.tx_cnt == stop_last(q.line_ctrl)) begin
                        d.tx_st = TX_IDLE;
                    end
                end
                default: d.tx_st = TX_IDLE;
            endcase
        end
        d.tx_pin = q.modem_ctrl[MC_LOOP] ? 1'b1 : (q.tx_line & ~q.line_ctrl[LC_BREAK]);

        // ------------------------------------------------------------
        // register writes
        // ------------------------------------------------------------
        if (wr) begin
            case (i_req.addr)
                OFS_DATA: begin
                    if (dlab) begin
                        d.div_lo = i_req.wdata;
                    end else begin
                        tx_push = 1'b1;
                    end
                end
                OFS_IRQ_EN: begin
                    if (dlab) begin
                        d.div_hi = i_req.wdata;
                    end else begin
                        d.irq_en = i_req.wdata[3:0];
                    end
                end
                OFS_FIFO: begin
                    d.fifo_en = i_req.wdata[FC_ENABLE];
                    // switching mode flushes both queues
                    rx_rst = i_req.wdata[FC_RX_RST] | (i_req.wdata[FC_ENABLE] != q.fifo_en);
                    tx_rst = i_req.wdata[FC_TX_RST] | (i_req.wdata[FC_ENABLE] != q.fifo_en);
                end
                OFS_LINE_CTRL: d.line_ctrl = i_req.wdata;
                OFS_MODEM_CTRL: d.modem_ctrl = i_req.wdata[4:0];
                OFS_SCRATCH: d.scratch = i_req.wdata;
                default: d.scratch = q.scratch;
            endcase
        end
        // modem outputs park inactive in loopback
        d.mdm_out_n = ~({d.modem_ctrl[MC_RTS], d.modem_ctrl[MC_DTR]}
                      & {2{~d.modem_ctrl[MC_LOOP]}});

        // ------------------------------------------------------------
        // register reads and their side effects
        // ------------------------------------------------------------
        lsr_val = {q.fifo_err & q.fifo_en, q.temt, q.thre, q.head_err, q.overrun,
                   q.rx_count != 5'h00};
        pending = (q.irq_en[IE_LS] & (q.overrun | (|q.head_err)))
                | (q.irq_en[IE_RX] & (q.rx_count != 5'h00))
                | (q.irq_en[IE_TX] & q.thre)
                | (q.irq_en[IE_MS] & (|q.m_delta));
        if (q.irq_en[IE_LS] & (q.overrun | (|q.head_err))) begin
            iid = IID_LS;
        end else if (q.irq_en[IE_RX] & (q.rx_count != 5'h00)) begin
            iid = IID_RX;
        end else if (q.irq_en[IE_TX] & q.thre) begin
            iid = IID_TX;
        end else begin
            iid = IID_MS;
        end
        d.irq = q.modem_ctrl[MC_IRQ_EN] & pending;
        lsr_rd = rd && (i_req.addr == OFS_LINE_STAT);
        rx_pop = rd && (i_req.addr == OFS_DATA) && !dlab && (q.rx_count != 5'h00);
        if (rd) begin
            case (i_req.addr)
                OFS_DATA: d.rdata = dlab ? q.div_lo : q.rx_mem[q.rx_rp][7:0];
                OFS_IRQ_EN: d.rdata = dlab ? q.div_hi : {4'h0, q.irq_en};
                OFS_FIFO: d.rdata = {{2{q.fifo_en}}, 2'h0, iid, ~pending};
                OFS_LINE_CTRL: d.rdata = q.line_ctrl;
                OFS_MODEM_CTRL: d.rdata = {3'h0, q.modem_ctrl};
                OFS_LINE_STAT: d.rdata = lsr_val;
                OFS_MODEM_STAT: d.rdata = {q.m_stat, q.m_delta};
                default: d.rdata = q.scratch;
            endcase
        end
        // change flags: a new change beats the clearing read
        d.m_delta = ((rd && i_req.addr == OFS_MODEM_STAT) ? 4'h0 : q.m_delta)
                  | {q.m_stat[3] ^ m_now[3], q.m_stat[2] & ~m_now[2],
                     q.m_stat[1] ^ m_now[1], q.m_stat[0] ^ m_now[0]};

        // ------------------------------------------------------------
        // receive queue (depth one in legacy mode)
        // ------------------------------------------------------------
        if (rx_done) begin
            if ((q.rx_count < cap) || rx_pop) begin
                rx_push = 1'b1;
                d.rx_mem[q.rx_wp] = rx_ent;
                d.rx_wp = 4'(q.rx_wp + 4'h1);
            end else begin
                d.overrun = 1'b1;
                if (!q.fifo_en) begin
                    // legacy: the unread character is overwritten
                    d.rx_mem[q.rx_rp] = rx_ent;
                    head_set = {rx_ent.brk, rx_ent.fe, rx_ent.pe};
                end
            end
        end
        if (rx_pop) begin
            d.rx_rp = 4'(q.rx_rp + 4'h1);
            next_head = (q.rx_count > 5'h01) ? lsm_rx_ent_t'(q.rx_mem[4'(q.rx_rp + 4'h1)]) : rx_ent;
            if ((q.rx_count > 5'h01) || rx_push) begin
                head_set = {next_head.brk, next_head.fe, next_head.pe};
            end
        end else if (rx_push && (q.rx_count == 5'h00)) begin
            head_set = {rx_ent.brk, rx_ent.fe, rx_ent.pe};
        end
        d.rx_count = 5'(q.rx_count + {4'h0, rx_push} - {4'h0, rx_pop});
        d.rx_errs = 5'(q.rx_errs
                  + {4'h0, rx_push & (rx_ent.brk | rx_ent.fe | rx_ent.pe)}
                  - {4'h0, rx_pop & (|q.rx_mem[q.rx_rp][10:8])});
        if (rx_rst) begin
            d.rx_wp = 4'h0;
            d.rx_rp = 4'h0;
            d.rx_count = 5'h00;
            d.rx_errs = 5'h00;
        end

        // status flags: a setting event beats the clearing read
        d.overrun = (lsr_rd ? 1'b0 : q.overrun) | (rx_done & ~rx_push);
        d.head_err = (lsr_rd ? 3'h0 : q.head_err) | head_set;
        d.fifo_err = d.fifo_en & ((d.rx_errs != 5'h00)
                   | (q.fifo_err & ~lsr_rd));

        // ------------------------------------------------------------
        // transmit queue (depth one in legacy mode)
        // ------------------------------------------------------------
        if (tx_push && (q.tx_count < cap || tx_pop)) begin
            d.tx_mem[q.tx_wp] = i_req.wdata;
            d.tx_wp = 4'(q.tx_wp + 4'h1);
        end else begin
            tx_push = 1'b0;
        end
        if (tx_pop) begin
            d.tx_rp = 4'(q.tx_rp + 4'h1);
        end
        d.tx_count = 5'(q.tx_count + {4'h0, tx_push} - {4'h0, tx_pop});
        if (wr && i_req.addr == OFS_DATA && !dlab) begin
            d.thre = 1'b0;
        end else if (tx_pop && q.tx_count == 5'h01) begin
            d.thre = 1'b1;
        end
        if (tx_rst) begin
            d.tx_wp = 4'h0;
            d.tx_rp = 4'h0;
            d.tx_count = 5'h00;
            d.thre = 1'b1;
        end
        d.temt = (d.tx_count == 5'h00) && (d.tx_st == TX_IDLE);
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            q <= '0;
            q.rx_sync <= 3'h7;
            q.rx_line <= 1'b1;
            q.m_sync0 <= 4'hf;
            q.m_sync1 <= 4'hf;
            q.m_sync2 <= 4'hf;
            q.m_pin <= 4'hf;
            q.tx_line <= 1'b1;
            q.tx_pin <= 1'b1;
            q.thre <= 1'b1;
            q.temt <= 1'b1;
            q.mdm_out_n <= 2'h3;
        end else begin
            q <= d;
        end
    end

    assign o_rdata = q.rdata;
    assign o_tx = q.tx_pin;
    assign o_irq = q.irq;
    assign o_rts_n = q.mdm_out_n[1];
    assign o_dtr_n = q.mdm_out_n[0];
endmodule : lsm_uart
`default_nettype wire

// ### lsm_pkg.sv
`default_nettype none
package lsm_pkg;
    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [2:0] OFS_DATA = 3'h0;
    localparam logic [2:0] OFS_IRQ_EN = 3'h1;
    localparam logic [2:0] OFS_FIFO = 3'h2;
    localparam logic [2:0] OFS_LINE_CTRL = 3'h3;
    localparam logic [2:0] OFS_MODEM_CTRL = 3'h4;
    localparam logic [2:0] OFS_LINE_STAT = 3'h5;
    localparam logic [2:0] OFS_MODEM_STAT = 3'h6;
    localparam logic [2:0] OFS_SCRATCH = 3'h7;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int LC_STOP = 2;
    localparam int LC_PAR_EN = 3;
    localparam int LC_PAR_EVEN = 4;
    localparam int LC_PAR_STICK = 5;
    localparam int LC_BREAK = 6;
    localparam int LC_DLAB = 7;
    localparam int FC_ENABLE = 0;
    localparam int FC_RX_RST = 1;
    localparam int FC_TX_RST = 2;
    localparam int MC_DTR = 0;
    localparam int MC_RTS = 1;
    localparam int MC_RI = 2;
    localparam int MC_IRQ_EN = 3;
    localparam int MC_LOOP = 4;
    localparam int IE_RX = 0;
    localparam int IE_TX = 1;
    localparam int IE_LS = 2;
    localparam int IE_MS = 3;
    // ------------------------------------------------------------
    // sizes, interrupt codes, timing
    // ------------------------------------------------------------
    localparam int FIFO_DEPTH = 16;
    localparam logic [4:0] CAP_FIFO = 5'h10;
    localparam logic [4:0] CAP_LEGACY = 5'h01;
    localparam logic [3:0] OVS_LAST = 4'hf;
    localparam logic [3:0] OVS_MID = 4'h7;
    localparam logic [4:0] STOP1_LAST = 5'h0f;
    localparam logic [4:0] STOP15_LAST = 5'h17;
    localparam logic [4:0] STOP2_LAST = 5'h1f;
    localparam logic [3:0] LEN_MIN = 4'h5;
    localparam logic [2:0] IID_LS = 3'h3;
    localparam logic [2:0] IID_RX = 3'h2;
    localparam logic [2:0] IID_TX = 3'h1;
    localparam logic [2:0] IID_MS = 3'h0;
    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP, RX_HOLD} lsm_rx_st_t;
    typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP} lsm_tx_st_t;
    typedef struct packed {
        logic brk;
        logic fe;
        logic pe;
        logic [7:0] data;
    } lsm_rx_ent_t;
    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } lsm_bus_req_t;
    // active-low modem inputs, ordered as the status nibble
    typedef struct packed {
        logic dcd_n;
        logic ri_n;
        logic dsr_n;
        logic cts_n;
    } lsm_modem_in_t;
endpackage : lsm_pkg
`default_nettype wire

// ### lsm_uart_props.sv
`default_nettype none
module lsm_uart_props
    import lsm_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire lsm_bus_req_t i_req,
    input wire logic [7:0] o_rdata,
    input wire logic i_rx,
    input wire logic o_tx,
    input wire lsm_modem_in_t i_modem_n,
    input wire logic o_rts_n,
    input wire logic o_dtr_n,
    input wire logic o_irq
);
    logic fen_q, dlab_q, brk_q, ien_q;
    logic [5:0] idle_q;
    wire logic rd_ls = i_req.rd && i_req.addr == OFS_LINE_STAT;
    wire logic wr_a = i_req.wr;
    // a long quiet line means no frame can end and set a flag meanwhile
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            {fen_q, dlab_q, brk_q, ien_q, idle_q} <= '0;
        end else begin
            if (wr_a && i_req.addr == OFS_FIFO) fen_q <= i_req.wdata[FC_ENABLE];
            if (wr_a && i_req.addr == OFS_LINE_CTRL) {dlab_q, brk_q} <= i_req.wdata[7:6];
            if (wr_a && i_req.addr == OFS_MODEM_CTRL) ien_q <= i_req.wdata[MC_IRQ_EN];
            idle_q <= !i_rx ? 6'h00 : idle_q + {5'h00, idle_q != 6'h3f};
        end
    end
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_rst_n);
    AST_RDATA_IDLE: assert property (!i_req.rd |=> o_rdata == 8'h00)
        else $error("read data not idle");
    AST_RFE_LEGACY: assert property (rd_ls && !fen_q |=> !o_rdata[7])
        else $error("fifo error bit set in legacy mode");
    AST_THRE_CLR: assert property ((wr_a && i_req.addr == OFS_DATA && !dlab_q) ##1 rd_ls
        |=> o_rdata[6:5] == 2'b00) else $error("empty flags not cleared by write");
    AST_LSR_CLR: assert property ((rd_ls && idle_q > 6'h28) ##2 rd_ls
        |=> o_rdata[4:1] == 4'h0) else $error("error flags survive status read");
    AST_RDY_CLR: assert property ((i_req.rd && i_req.addr == OFS_DATA && !dlab_q && !fen_q
        && idle_q > 6'h28) ##2 rd_ls |=> !o_rdata[0]) else $error("ready stays set");
    AST_TEMT_TX: assert property ((rd_ls && !brk_q) ##1 o_rdata[6] |-> $past(o_tx))
        else $error("line low while shifter empty");
    AST_IRQ_OFF: assert property (!ien_q ##1 !ien_q |-> !o_irq)
        else $error("interrupt while output disabled");
    AST_IER_MAP: assert property (i_req.rd && i_req.addr == OFS_IRQ_EN && !dlab_q
        |=> o_rdata[7:4] == 4'h0) else $error("enable register high bits set");
endmodule : lsm_uart_props
`default_nettype wire

// ### lsm_peer.sv
`default_nettype none
module lsm_peer (
    input wire logic i_clk_sys,
    input wire logic i_line_in,
    output var logic o_line
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam int BIT = 16;
    initial o_line = 1'b1;
    task automatic bitout(input logic v);
        o_line <= v;
        repeat (BIT) @(posedge i_clk_sys);
    endtask : bitout
    // two idle bits after every frame so a low stop bit never merges into the next start
    task automatic send(input logic [7:0] d, input logic p_en, input logic p_v, input logic s);
        bitout(1'b0);
        for (int i = 0; i < 8; i++) bitout(d[i]);
        if (p_en) bitout(p_v);
        bitout(s);
        bitout(1'b1);
        bitout(1'b1);
    endtask : send
    task automatic rcv(output logic [7:0] d);
        for (int i = 0; i < 400 && i_line_in === 1'b1; i++) @(posedge i_clk_sys);
        repeat (BIT / 2) @(posedge i_clk_sys);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT) @(posedge i_clk_sys);
            d[i] = i_line_in;
        end
    endtask : rcv
endmodule : lsm_peer
`default_nettype wire

// ### lsm_uart_tb_top.sv
`default_nettype none
module lsm_uart_tb_top
    import lsm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    lsm_bus_req_t req = '0;
    logic [7:0] rdata, d;
    logic tx, rx, irq, rts_n, dtr_n;
    int errors = 0;
    int checks_done = 0;
    int cyc = 0;
    always #5 clk = ~clk;
    lsm_uart lsm_uart_i (.i_clk_sys(clk), .i_rst_n(rst_n), .i_req(req), .o_rdata(rdata),
        .i_rx(rx), .o_tx(tx), .i_modem_n(4'hf), .o_rts_n(rts_n), .o_dtr_n(dtr_n),
        .o_irq(irq));
    lsm_peer lsm_peer_i (.i_clk_sys(clk), .i_line_in(tx), .o_line(rx));
    task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
        checks_done++;
        if (s !== e) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    // one access, then an idle cycle
    task automatic acc(input logic [2:0] a, input logic [7:0] v, input logic w);
        req <= '{a, v, w, !w};
        @(posedge clk);
        req <= '0;
        @(negedge clk);
        @(posedge clk);
    endtask : acc
    task automatic rd(input logic [2:0] a, input logic [7:0] e);
        req <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clk);
        req <= '0;
        @(negedge clk);
        chk("rdata", rdata, e);
        @(posedge clk);
    endtask : rd
    task automatic complete_run;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : complete_run
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            errors++;
            complete_run();
        end
    end
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        rd(3'h5, 8'h60);
        acc(3'h3, 8'h83, 1'b1);
        acc(3'h0, 8'h01, 1'b1);
        acc(3'h1, 8'h00, 1'b1);
        rd(3'h0, 8'h01);
        acc(3'h3, 8'h03, 1'b1);
        acc(3'h1, 8'h02, 1'b1);
        rd(3'h1, 8'h02);
        acc(3'h4, 8'h0b, 1'b1);
        // irq updates on this edge (the modem outputs one edge earlier), so look half a cycle later
        @(negedge clk);
        chk("irq", {7'h00, irq}, 8'h01);
        chk("modem_out", {6'h00, rts_n, dtr_n}, 8'h00);
        @(posedge clk);
        acc(3'h1, 8'h00, 1'b1);
        req <= '{3'h0, 8'ha5, 1'b1, 1'b0};
        @(posedge clk);
        rd(3'h5, 8'h00);
        lsm_peer_i.rcv(d);
        chk("tx", d, 8'ha5);
        repeat (30) @(posedge clk);
        rd(3'h5, 8'h60);
        lsm_peer_i.send(8'h3c, 1'b0, 1'b0, 1'b1);
        rd(3'h5, 8'h61);
        rd(3'h0, 8'h3c);
        rd(3'h5, 8'h60);
        acc(3'h3, 8'h1b, 1'b1);
        lsm_peer_i.send(8'h01, 1'b1, 1'b0, 1'b1);
        rd(3'h5, 8'h65);
        rd(3'h5, 8'h61);
        rd(3'h0, 8'h01);
        acc(3'h3, 8'h03, 1'b1);
        lsm_peer_i.send(8'h11, 1'b0, 1'b0, 1'b1);
        lsm_peer_i.send(8'h22, 1'b0, 1'b0, 1'b1);
        rd(3'h5, 8'h63);
        rd(3'h0, 8'h22);
        lsm_peer_i.send(8'h00, 1'b0, 1'b0, 1'b0);
        rd(3'h5, 8'h79);
        rd(3'h0, 8'h00);
        acc(3'h2, 8'h01, 1'b1);
        lsm_peer_i.send(8'h7e, 1'b0, 1'b0, 1'b0);
        lsm_peer_i.send(8'h5a, 1'b0, 1'b0, 1'b1);
        rd(3'h5, 8'he9);
        rd(3'h5, 8'he1);
        rd(3'h0, 8'h7e);
        rd(3'h5, 8'he1);
        rd(3'h5, 8'h61);
        rd(3'h0, 8'h5a);
        complete_run();
    end
endmodule : lsm_uart_tb_top
bind lsm_uart lsm_uart_props lsm_uart_props_i (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
    .i_req(i_req), .o_rdata(o_rdata), .i_rx(i_rx), .o_tx(o_tx), .i_modem_n(i_modem_n),
    .o_rts_n(o_rts_n), .o_dtr_n(o_dtr_n), .o_irq(o_irq));
`default_nettype wire
